/* design/lcff_top.sv */
// Latched, clear-on-read fault flags of a two-channel LED controller.
// Assumes the serial register port issues a one-cycle read strobe on this clock.
`timescale 1ns/1ps
`include "lcff_regs.svh"

module lcff_top (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    ce,
	input  wire logic                    nrst,
	// Channel 1 converter results and settings
	input  wire lcff_pkg::lcff_code_t    ch1_vout_code,
	input  wire logic                    ch1_vout_valid,
	input  wire lcff_pkg::lcff_code_t    ch1_current_code,
	input  wire logic                    ch1_current_valid,
	input  wire lcff_pkg::lcff_setting_t ch1_current_setting,
	input  wire logic [1:0]              ch1_short_threshold_sel,
	// Channel 2 converter results and settings
	input  wire lcff_pkg::lcff_code_t    ch2_vout_code,
	input  wire logic                    ch2_vout_valid,
	input  wire lcff_pkg::lcff_code_t    ch2_current_code,
	input  wire logic                    ch2_current_valid,
	input  wire lcff_pkg::lcff_setting_t ch2_current_setting,
	input  wire logic [1:0]              ch2_short_threshold_sel,
	// Thermal conditions
	input  wire logic                    thermal_shutdown_cond,
	input  wire logic                    thermal_warning_cond,
	// Register read port
	input  wire logic                    read_stb,
	output lcff_pkg::lcff_flags_t        read_data_r,
	output logic                         read_valid_r,
	// Live flags and summary
	output lcff_pkg::lcff_flags_t        general_fault_flags_r,
	output logic [3:0]                   fault_summary_bits_r
);

	lcff_pkg::lcff_flags_t cond;
	lcff_pkg::lcff_flags_t flags_nxt;
	logic [3:0]            summary_nxt;

	// ----------------------------------------------------------------
	// Per-channel conditions
	// ----------------------------------------------------------------
	lcff_chan u_ch1 (
		.clk                 (clk),
		.ce                  (ce),
		.nrst                (nrst),
		.vout_code           (ch1_vout_code),
		.vout_valid          (ch1_vout_valid),
		.current_code        (ch1_current_code),
		.current_valid       (ch1_current_valid),
		.current_setting     (ch1_current_setting),
		.short_threshold_sel (ch1_short_threshold_sel),
		.cond                (cond[`LCFF_CH1_LSB +: 4])
	);

	lcff_chan u_ch2 (
		.clk                 (clk),
		.ce                  (ce),
		.nrst                (nrst),
		.vout_code           (ch2_vout_code),
		.vout_valid          (ch2_vout_valid),
		.current_code        (ch2_current_code),
		.current_valid       (ch2_current_valid),
		.current_setting     (ch2_current_setting),
		.short_threshold_sel (ch2_short_threshold_sel),
		.cond                (cond[`LCFF_CH2_LSB +: 4])
	);

	assign cond[`LCFF_BIT_THERMAL_SHUTDOWN_FLAG] = thermal_shutdown_cond;
	assign cond[`LCFF_BIT_THERMAL_WARNING_FLAG] = thermal_warning_cond;

	// ----------------------------------------------------------------
	// Flag latches
	// ----------------------------------------------------------------
	// A live condition sets its flag at every enabled edge, so an event in the read cycle is kept.
	genvar i;
	generate
		for (i = 0; i < 10; i++) begin : g_flag
			assign flags_nxt[i] = cond[i] |
				(general_fault_flags_r[i] & ~read_stb);

			always_ff @(posedge clk) begin
				if (!nrst) begin
					general_fault_flags_r[i] <= 1'b0;
				end else if (ce) begin
					general_fault_flags_r[i] <= flags_nxt[i];
				end
			end

			flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
				ce && cond[i] |=> general_fault_flags_r[i])
				else $error("flag missed its condition");

			flag_clear_a: assert property (@(posedge clk) disable iff (!nrst)
				ce && read_stb && !cond[i] |=> !general_fault_flags_r[i])
				else $error("flag not cleared by read");

			flag_hold_a: assert property (@(posedge clk) disable iff (!nrst)
				general_fault_flags_r[i] && !(ce && read_stb) |=> general_fault_flags_r[i])
				else $error("flag dropped without a read");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			read_data_r <= `LCFF_FLAGS_RESET;
		end else if (ce && read_stb) begin
			read_data_r <= general_fault_flags_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			read_valid_r <= 1'b0;
		end else if (ce) begin
			read_valid_r <= read_stb;
		end
	end

	read_data_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && read_stb |=> read_valid_r && read_data_r == $past(general_fault_flags_r))
		else $error("read data does not match flags");

	// ----------------------------------------------------------------
	// Summary nibble
	// ----------------------------------------------------------------
	always_comb begin
		summary_nxt[3] = flags_nxt[`LCFF_CH1_LSB + `LCFF_OFS_OVP] |
			flags_nxt[`LCFF_CH2_LSB + `LCFF_OFS_OVP];
		summary_nxt[2] = flags_nxt[`LCFF_CH1_LSB + `LCFF_OFS_OVERC] |
			flags_nxt[`LCFF_CH2_LSB + `LCFF_OFS_OVERC];
		summary_nxt[1] = |{flags_nxt[`LCFF_CH1_LSB +: 2], flags_nxt[`LCFF_CH2_LSB +: 2]};
		summary_nxt[0] = flags_nxt[`LCFF_BIT_THERMAL_SHUTDOWN_FLAG] | flags_nxt[`LCFF_BIT_THERMAL_WARNING_FLAG];
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			fault_summary_bits_r <= 4'h0;
		end else if (ce) begin
			fault_summary_bits_r <= summary_nxt;
		end
	end

	summary_or_a: assert property (@(posedge clk) disable iff (!nrst)
		fault_summary_bits_r == {
			general_fault_flags_r[7] | general_fault_flags_r[3],
			general_fault_flags_r[6] | general_fault_flags_r[2],
			|{general_fault_flags_r[5:4], general_fault_flags_r[1:0]},
			general_fault_flags_r[9] | general_fault_flags_r[8]})
		else $error("summary nibble disagrees with flags");

	reset_clear_a: assert property (@(posedge clk)
		!nrst |=> general_fault_flags_r == `LCFF_FLAGS_RESET && fault_summary_bits_r == 4'h0)
		else $error("flags not cleared by reset");

	// ----------------------------------------------------------------
	// Clock enable and read port checks
	// ----------------------------------------------------------------
	freeze_state_a: assert property (@(posedge clk) disable iff (!nrst)
		!ce |=> $stable(general_fault_flags_r) && $stable(fault_summary_bits_r) &&
			$stable(read_data_r) && $stable(read_valid_r))
		else $error("state moved while clock enable was low");

	read_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && !read_stb |=> !read_valid_r)
		else $error("read valid raised without a read strobe");

	read_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		!(ce && read_stb) |=> $stable(read_data_r))
		else $error("read data changed without a read");

	// ----------------------------------------------------------------
	// Converter results to flag positions
	// ----------------------------------------------------------------
	// A result taken here is judged at the next enabled edge, so settings must hold that long.
	function automatic lcff_pkg::lcff_code_t short_level(logic [1:0] sel);
		lcff_pkg::lcff_code_t lvl;
		case (sel)
			2'h0:    lvl = `LCFF_SHORT_THR_0;
			2'h1:    lvl = `LCFF_SHORT_THR_1;
			2'h2:    lvl = `LCFF_SHORT_THR_2;
			default: lvl = `LCFF_SHORT_THR_3;
		endcase
		return lvl;
	endfunction : short_level

	ch1_ovp_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && ch1_vout_valid && ch1_vout_code == `LCFF_VOUT_FULL ##1 ce
		|=> general_fault_flags_r[`LCFF_CH1_LSB + `LCFF_OFS_OVP])
		else $error("channel 1 overvoltage flag not raised");

	ch2_ovp_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && ch2_vout_valid && ch2_vout_code == `LCFF_VOUT_FULL ##1 ce
		|=> general_fault_flags_r[`LCFF_CH2_LSB + `LCFF_OFS_OVP])
		else $error("channel 2 overvoltage flag not raised");

	ch1_overc_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && ch1_current_valid && ch1_current_setting >= `LCFF_SET_MIN &&
			({3'h0, ch1_current_code} * 11'h004) > ({4'h0, ch1_current_setting} * 11'h005)
			##1 ce && $stable(ch1_current_setting)
		|=> general_fault_flags_r[`LCFF_CH1_LSB + `LCFF_OFS_OVERC])
		else $error("channel 1 overcurrent flag not raised");

	ch2_overc_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && ch2_current_valid && ch2_current_setting >= `LCFF_SET_MIN &&
			({3'h0, ch2_current_code} * 11'h004) > ({4'h0, ch2_current_setting} * 11'h005)
			##1 ce && $stable(ch2_current_setting)
		|=> general_fault_flags_r[`LCFF_CH2_LSB + `LCFF_OFS_OVERC])
		else $error("channel 2 overcurrent flag not raised");

	ch1_open_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && ch1_current_valid && ch1_current_setting >= `LCFF_SET_MIN &&
			({3'h0, ch1_current_code} * 11'h004) < ({4'h0, ch1_current_setting} * 11'h003)
			##1 ce && $stable(ch1_current_setting)
		|=> general_fault_flags_r[`LCFF_CH1_LSB + `LCFF_OFS_OPEN])
		else $error("channel 1 open flag not raised");

	ch2_open_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && ch2_current_valid && ch2_current_setting >= `LCFF_SET_MIN &&
			({3'h0, ch2_current_code} * 11'h004) < ({4'h0, ch2_current_setting} * 11'h003)
			##1 ce && $stable(ch2_current_setting)
		|=> general_fault_flags_r[`LCFF_CH2_LSB + `LCFF_OFS_OPEN])
		else $error("channel 2 open flag not raised");

	ch1_short_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && ch1_vout_valid && ch1_current_setting >= `LCFF_SET_MIN &&
			ch1_vout_code < short_level(ch1_short_threshold_sel)
			##1 ce && $stable(ch1_current_setting) && $stable(ch1_short_threshold_sel)
		|=> general_fault_flags_r[`LCFF_CH1_LSB + `LCFF_OFS_SHORT])
		else $error("channel 1 short flag not raised");

	ch2_short_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && ch2_vout_valid && ch2_current_setting >= `LCFF_SET_MIN &&
			ch2_vout_code < short_level(ch2_short_threshold_sel)
			##1 ce && $stable(ch2_current_setting) && $stable(ch2_short_threshold_sel)
		|=> general_fault_flags_r[`LCFF_CH2_LSB + `LCFF_OFS_SHORT])
		else $error("channel 2 short flag not raised");

endmodule : lcff_top

/* design/lcff_regs.svh */
// Constants for the LED channel fault flag block: field positions, reset values, thresholds.
// Assumes it is included by the design files of this block only.
//
// Behaviour
// - Channel 1 short flag, bit 5, sets when output code falls below chosen threshold.
// - Channel 1 open flag, bit 4, sets when current code below 0.75 of setting.
// - Channel 2 overvoltage flag, bit 3, sets when output code is full scale.
// - Channel 2 overcurrent flag, bit 2, sets when current exceeds 1.25 of setting.
// - Channel 2 short flag, bit 1, sets when output code falls below chosen threshold.
// - Channel 2 open flag, bit 0, sets when current code below 0.75 of setting.
// - Short, open and overcurrent checks run only while setting is at least 21h.
// - Flags latch; a read clears a flag only when its condition has gone.
// - Summary nibble ORs overvoltage, overcurrent, short or open, and thermal flags.
// - Channel 1 overcurrent flag, bit 6, sets when current exceeds 1.25 of setting.
// - Channel 1 overvoltage flag, bit 7, sets when output code is full scale.
`ifndef LCFF_REGS_SVH
`define LCFF_REGS_SVH

// ----------------------------------------------------------------
// Field positions in the fault flag word
// ----------------------------------------------------------------
`define LCFF_BIT_THERMAL_SHUTDOWN_FLAG   9
`define LCFF_BIT_THERMAL_WARNING_FLAG   8
`define LCFF_CH1_LSB       4
`define LCFF_CH2_LSB       0
`define LCFF_OFS_OVP       3
`define LCFF_OFS_OVERC     2
`define LCFF_OFS_SHORT     1
`define LCFF_OFS_OPEN      0

// ----------------------------------------------------------------
// Reset values and thresholds
// ----------------------------------------------------------------
`define LCFF_FLAGS_RESET   10'h000
`define LCFF_CODE_RESET    8'h00
`define LCFF_VOUT_FULL     8'hFF
`define LCFF_SET_MIN       7'h21
`define LCFF_SHORT_THR_0   8'h20
`define LCFF_SHORT_THR_1   8'h40
`define LCFF_SHORT_THR_2   8'h60
`define LCFF_SHORT_THR_3   8'h80

`endif

/* design/lcff_pkg.sv */
// Types shared by the LED channel fault flag block.
// Assumes nothing of its surroundings.
package lcff_pkg;
	typedef logic [7:0] lcff_code_t;
	typedef logic [6:0] lcff_setting_t;
	typedef logic [9:0] lcff_flags_t;
	typedef logic [3:0] lcff_chan_flags_t;
endpackage : lcff_pkg

/* design/lcff_chan.sv */
// One channel's fault conditions, computed from its latest converter results.
// Assumes converter results and settings come from logic on the same clock.
`timescale 1ns/1ps
`include "lcff_regs.svh"

module lcff_chan (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   ce,
	input  wire logic                   nrst,
	// Converter results
	input  wire lcff_pkg::lcff_code_t   vout_code,
	input  wire logic                   vout_valid,
	input  wire lcff_pkg::lcff_code_t   current_code,
	input  wire logic                   current_valid,
	// Settings
	input  wire lcff_pkg::lcff_setting_t current_setting,
	input  wire logic [1:0]             short_threshold_sel,
	// Conditions: overvoltage, overcurrent, short, open
	output lcff_pkg::lcff_chan_flags_t  cond
);

	lcff_pkg::lcff_code_t vout_r;
	lcff_pkg::lcff_code_t cur_r;
	lcff_pkg::lcff_code_t short_thr;
	logic                 check_en;
	logic [10:0]          cur_x4;
	logic [10:0]          set_x3;
	logic [10:0]          set_x5;

	// ----------------------------------------------------------------
	// Latest completed results
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			vout_r <= `LCFF_CODE_RESET;
		end else if (ce && vout_valid) begin
			vout_r <= vout_code;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cur_r <= `LCFF_CODE_RESET;
		end else if (ce && current_valid) begin
			cur_r <= current_code;
		end
	end

	// ----------------------------------------------------------------
	// Comparisons
	// ----------------------------------------------------------------
	always_comb begin
		case (short_threshold_sel)
			2'h0:    short_thr = `LCFF_SHORT_THR_0;
			2'h1:    short_thr = `LCFF_SHORT_THR_1;
			2'h2:    short_thr = `LCFF_SHORT_THR_2;
			default: short_thr = `LCFF_SHORT_THR_3;
		endcase
	end

	// Ratios are compared scaled by four so no fractions are needed.
	assign cur_x4   = {1'b0, cur_r, 2'b00};
	assign set_x3   = 11'({4'h0, current_setting} * 11'h003);
	assign set_x5   = 11'({4'h0, current_setting} * 11'h005);
	assign check_en = (current_setting >= `LCFF_SET_MIN);

	assign cond[`LCFF_OFS_OVP]   = (vout_r == `LCFF_VOUT_FULL);
	assign cond[`LCFF_OFS_OVERC] = check_en && (cur_x4 > set_x5);
	assign cond[`LCFF_OFS_SHORT] = check_en && (vout_r < short_thr);
	assign cond[`LCFF_OFS_OPEN]  = check_en && (cur_x4 < set_x3);

	gate_low_a: assert property (@(posedge clk) disable iff (!nrst)
		!check_en |-> cond[2:0] == 3'h0)
		else $error("check active with low current setting");

	full_scale_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && vout_valid && vout_code == `LCFF_VOUT_FULL |=> cond[`LCFF_OFS_OVP])
		else $error("full scale output did not raise overvoltage");

endmodule : lcff_chan

/* verification/lcff_reader.sv */
// Partner model: register port host that reads the fault flag word.
// Assumes the bench clock and a one-cycle read strobe contract.
`timescale 1ns/1ps

module lcff_reader (
	// Clock
	input  wire logic                  clk,
	// Read port
	output logic                       read_stb,
	input  wire lcff_pkg::lcff_flags_t read_data_r,
	input  wire logic                  read_valid_r
);
	initial read_stb = 1'b0;

	// One read strobe, then wait for the answer under a bound.
	task automatic read_word(output lcff_pkg::lcff_flags_t w);
		int n;
		n = 0;
		@(negedge clk);
		read_stb = 1'b1;
		@(negedge clk);
		read_stb = 1'b0;
		while (read_valid_r !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		// A missed answer returns unknowns so that the caller's compare fails.
		w = (read_valid_r === 1'b1) ? read_data_r : 'x;
	endtask : read_word
endmodule : lcff_reader

/* verification/lcff_top_tb.sv */
// Self-checking bench for the fault flag block.
// Assumes the design files and the reader model are compiled first.
`timescale 1ns/1ps

module lcff_top_tb;
	logic                    clk, ce, nrst, ts, tw, rs, rv;
	lcff_pkg::lcff_code_t    vo[2], cu[2];
	lcff_pkg::lcff_setting_t st[2];
	logic [1:0]              th[2];
	logic                    vv[2], cv[2];
	lcff_pkg::lcff_flags_t   rd, fl, w;
	logic [3:0]              sm;
	int                      n_fail = 0;
	int                      cmp_count = 0;

	lcff_top lcff_top_i (.clk(clk), .ce(ce), .nrst(nrst),
		.ch1_vout_code(vo[0]), .ch1_vout_valid(vv[0]), .ch1_current_code(cu[0]),
		.ch1_current_valid(cv[0]), .ch1_current_setting(st[0]), .ch1_short_threshold_sel(th[0]),
		.ch2_vout_code(vo[1]), .ch2_vout_valid(vv[1]), .ch2_current_code(cu[1]),
		.ch2_current_valid(cv[1]), .ch2_current_setting(st[1]), .ch2_short_threshold_sel(th[1]),
		.thermal_shutdown_cond(ts), .thermal_warning_cond(tw), .read_stb(rs),
		.read_data_r(rd), .read_valid_r(rv), .general_fault_flags_r(fl),
		.fault_summary_bits_r(sm));
	lcff_reader lcff_reader_i (.clk(clk), .read_stb(rs), .read_data_r(rd), .read_valid_r(rv));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic drv(int c, logic [7:0] v, logic [7:0] i, logic [6:0] s, logic [1:0] t);
		@(negedge clk);
		vo[c] = v;
		cu[c] = i;
		vv[c] = 1'b1;
		cv[c] = 1'b1;
		@(negedge clk);
		vv[c] = 1'b0;
		cv[c] = 1'b0;
		// Settings follow the codes so that no edge pairs new settings with old codes.
		st[c] = s;
		th[c] = t;
		repeat (3) @(negedge clk);
	endtask : drv

	// Raise one condition, check flags and summary, remove it, read once.
	task automatic one(int c, logic [7:0] v, logic [7:0] i, logic [6:0] s, logic [1:0] t,
		logic [9:0] e);
		drv(c, v, i, s, t);
		chk("flags", e, fl);
		chk("summary", {6'h00, e[7] | e[3], e[6] | e[2], |{e[5:4], e[1:0]}, |e[9:8]}, sm);
		drv(c, 8'h80, 8'h40, 7'h40, 2'h0);
		lcff_reader_i.read_word(w);
		chk("read", e, w);
		chk("cleared", 10'h000, fl);
	endtask : one

	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_latch;
		drv(0, 8'hFF, 8'h40, 7'h40, 2'h0);
		chk("ch1_overvoltage", 10'h080, fl);
		lcff_reader_i.read_word(w);
		chk("read0", 10'h080, w);
		chk("held", 10'h080, fl);
		drv(0, 8'h80, 8'h40, 7'h40, 2'h0);
		lcff_reader_i.read_word(w);
		chk("read", 10'h080, w);
		chk("gone", 10'h000, fl);
		one(1, 8'hFF, 8'h40, 7'h00, 2'h0, 10'h008);
	endtask : t_latch

	task automatic t_current;
		one(0, 8'h80, 8'h51, 7'h40, 2'h0, 10'h040);
		one(0, 8'h80, 8'h50, 7'h40, 2'h0, 10'h000);
		one(1, 8'h80, 8'h51, 7'h40, 2'h0, 10'h004);
		one(0, 8'h80, 8'h2F, 7'h40, 2'h0, 10'h010);
		one(0, 8'h80, 8'h30, 7'h40, 2'h0, 10'h000);
		one(1, 8'h80, 8'h2F, 7'h40, 2'h0, 10'h001);
	endtask : t_current

	task automatic t_short;
		one(0, 8'h3F, 8'h40, 7'h40, 2'h1, 10'h020);
		one(0, 8'h40, 8'h40, 7'h40, 2'h1, 10'h000);
		one(0, 8'h5F, 8'h40, 7'h40, 2'h2, 10'h020);
		one(1, 8'h7F, 8'h40, 7'h40, 2'h3, 10'h002);
		one(1, 8'h1F, 8'h40, 7'h40, 2'h0, 10'h002);
	endtask : t_short

	task automatic t_gate;
		one(0, 8'h00, 8'h00, 7'h20, 2'h0, 10'h000);
		one(0, 8'h80, 8'h00, 7'h21, 2'h0, 10'h010);
		one(1, 8'h80, 8'hFF, 7'h20, 2'h0, 10'h000);
	endtask : t_gate

	task automatic t_therm;
		@(negedge clk);
		ts = 1'b1;
		tw = 1'b1;
		repeat (3) @(negedge clk);
		chk("therm", 10'h300, fl);
		chk("sum0", 10'h001, {6'h00, sm});
		ts = 1'b0;
		tw = 1'b0;
		lcff_reader_i.read_word(w);
		chk("tread", 10'h300, w);
		chk("tclr", 10'h000, fl);
	endtask : t_therm

	// A condition raised while the clock enable is low must not be latched until it rises.
	task automatic t_freeze;
		@(negedge clk);
		ce = 1'b0;
		ts = 1'b1;
		repeat (3) @(negedge clk);
		chk("frozen", 10'h000, fl);
		ce = 1'b1;
		@(negedge clk);
		chk("thawed", 10'h200, fl);
		chk("fsum", 10'h001, {6'h00, sm});
		ts = 1'b0;
		lcff_reader_i.read_word(w);
		chk("fread", 10'h200, w);
		chk("fclr", 10'h000, fl);
	endtask : t_freeze

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		#200us;
		n_fail++;
		tally_and_finish();
	end

	initial begin
		{ce, ts, tw} = 3'b100;
		nrst = 1'b0;
		for (int c = 0; c < 2; c++) begin
			{vo[c], cu[c], st[c], th[c]} = {8'h80, 8'h40, 7'h00, 2'h0};
			{vv[c], cv[c]} = 2'b00;
		end
		repeat (3) @(negedge clk);
		chk("reset", 10'h000, fl);
		chk("rsum", 10'h000, {6'h00, sm});
		nrst = 1'b1;
		// Codes reset to zero read as shorted and open, so load clean codes first.
		drv(0, 8'h80, 8'h40, 7'h40, 2'h0);
		drv(1, 8'h80, 8'h40, 7'h40, 2'h0);
		chk("idle", 10'h000, fl);
		t_latch();
		t_current();
		t_short();
		t_gate();
		t_therm();
		t_freeze();
		tally_and_finish();
	end
endmodule : lcff_top_tb
